// File: rtl/conv_frame_ctrl.v
// Conversion control, averaging and frame sequencing with result FIFO
// Behaviour
// - Average code 10b: output mean of two samples, half the rate.
// - Two-sample mode: ready rises one ready delay after second start.
// - Average code 11b: output sum of four samples over four.
// - Four starts per result; ready one ready delay after the fourth.
// - Acquire entered at power-up, wake, async reset, conversion done.
// - Power-down/reset falling edge moves acquire into reset state.
// - Start rising edge in acquire begins an internally timed conversion.
// - Short low pulse: abort, restore defaults, acquire after reset wake.
// - Long low pulse: power down, reset; acquire after power-down wake.
// - After reset, default mode-0 single-lane configure and read protocol.
// - Zone 1 shifts out current sample; cycle is delay plus read.
// - Zone 2: host reads after delay; device gives previous sample.
// - Shared pin carries strobe while select low, ready while high.
`include "conv_frame_regs.vh"

// ==========================================================================
// Result FIFO
module result_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clock,
	input  wire             rstn,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;
	wire            full;
	wire            empty;
	assign full      = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
	assign empty     = (wr_q == rd_q);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_q[AW-1:0]];
	always @(posedge clock) begin
		if (in_valid && !full)
			mem[wr_q[AW-1:0]] <= in_data;
	end
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wr_q <= wr_q + 1'b1;
			if (out_ready && !empty)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule // result_fifo

// ==========================================================================
// Conversion control top
module conv_frame_ctrl #(
	parameter RES             = 16,
	parameter PD_PULSE_CYCLES = `PD_PULSE_CYCLES,
	parameter PD_WAKE_CYCLES  = `PD_WAKE_CYCLES,
	parameter CW              = 16
) (
	input  wire            clock,
	input  wire            rstn,
	input  wire            conversion_start_pin,
	input  wire            powerdown_reset_n,
	input  wire            cs_n,
	input  wire [1:0]      avg_count_select,
	input  wire            zone2_select,
	input  wire            ready_mask,
	input  wire            strobe_in,
	input  wire [RES-1:0]  sample_a,
	input  wire [RES-1:0]  sample_b,
	output reg  [RES-1:0]  result_a_q,
	output reg  [RES-1:0]  result_b_q,
	output wire            result_valid,
	input  wire            result_ready,
	output wire            ready_strobe,
	output reg             acquire_state_q,
	output reg             convert_state_q,
	output reg             powered_down_q,
	output wire [2:0]      read_protocol
);
	// States, one-hot
	localparam [3:0] ST_ACQ  = 4'b0001;
	localparam [3:0] ST_CNV  = 4'b0010;
	localparam [3:0] ST_RST  = 4'b0100;
	localparam [3:0] ST_WAKE = 4'b1000;
	// Integer forms, cut to the counter width on purpose
	localparam integer  CONV_I  = `CONV_CYCLES;
	localparam integer  RWAKE_I = `RESET_WAKE_CYCLES;
	localparam integer  PPULS_I = PD_PULSE_CYCLES;
	localparam integer  PWAKE_I = PD_WAKE_CYCLES;
	localparam [CW-1:0] CONV_N  = CONV_I[CW-1:0];
	localparam [CW-1:0] RWAKE_N = RWAKE_I[CW-1:0];
	localparam [CW-1:0] PPULSE  = PPULS_I[CW-1:0];
	localparam [CW-1:0] PWAKE_N = PWAKE_I[CW-1:0];

	// ======================================================================
	// Pin synchronisers; a change counts when stages two and three agree
	reg [2:0] cst_s_q;
	reg [2:0] pdr_s_q;
	reg       cst_q;
	reg       pdr_q;
	wire      cst_rise;
	wire      pdr_fall;
	wire      pdr_rise;
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cst_s_q <= 3'h0;
			pdr_s_q <= 3'h7;
			cst_q   <= 1'b0;
			pdr_q   <= 1'b1;
		end else begin
			cst_s_q <= {cst_s_q[1:0], conversion_start_pin};
			pdr_s_q <= {pdr_s_q[1:0], powerdown_reset_n};
			if (cst_s_q[1] == cst_s_q[2])
				cst_q <= cst_s_q[2];
			if (pdr_s_q[1] == pdr_s_q[2])
				pdr_q <= pdr_s_q[2];
		end
	end
	assign cst_rise = (cst_s_q[1] == cst_s_q[2]) && cst_s_q[2] && !cst_q;
	assign pdr_fall = (pdr_s_q[1] == pdr_s_q[2]) && !pdr_s_q[2] && pdr_q;
	assign pdr_rise = (pdr_s_q[1] == pdr_s_q[2]) && pdr_s_q[2] && !pdr_q;

	// ======================================================================
	// Mode and averaging helpers
	function [2:0] avg_need;
		input [1:0] code;
		begin
			case (code)
				`AVG_TWO_CODE:  avg_need = 3'h2;
				`AVG_FOUR_CODE: avg_need = 3'h4;
				default:        avg_need = 3'h1;
			endcase
		end
	endfunction

	function [RES-1:0] avg_div;
		input [RES+1:0] sum;
		input [1:0]     code;
		begin
			case (code)
				`AVG_TWO_CODE:  avg_div = sum[RES:1];
				`AVG_FOUR_CODE: avg_div = sum[RES+1:2];
				default:        avg_div = sum[RES-1:0];
			endcase
		end
	endfunction

	// Sign-extend two's complement sample to accumulator width
	function [RES+1:0] sext;
		input [RES-1:0] v;
		begin
			sext = {{2{v[RES-1]}}, v};
		end
	endfunction

	// ======================================================================
	// State machine
	reg [3:0]    state_q;
	reg [CW-1:0] cnt_q;
	reg [CW-1:0] low_q;
	reg [1:0]    avg_cfg_q;
	reg [2:0]    taken_q;
	reg [RES+1:0] acc_a_q;
	reg [RES+1:0] acc_b_q;
	reg          push_q;
	reg          ready_q;
	reg          cs_seen_q;
	wire         fifo_in_ready;
	wire [RES+1:0] sum_a;
	wire [RES+1:0] sum_b;
	wire         last_sample;
	assign sum_a = acc_a_q + sext(sample_a);
	assign sum_b = acc_b_q + sext(sample_b);
	assign last_sample = (taken_q + 3'h1) >= avg_need(avg_cfg_q);

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q         <= ST_ACQ;
			cnt_q           <= {CW{1'b0}};
			low_q           <= {CW{1'b0}};
			avg_cfg_q       <= `AVG_RESET_VAL;
			taken_q         <= 3'h0;
			acc_a_q         <= {(RES+2){1'b0}};
			acc_b_q         <= {(RES+2){1'b0}};
			push_q          <= 1'b0;
			result_a_q      <= {RES{1'b0}};
			result_b_q      <= {RES{1'b0}};
			powered_down_q  <= 1'b0;
		end else begin
			push_q <= 1'b0;
			case (state_q)
				ST_ACQ: begin
					avg_cfg_q <= avg_count_select;
					if (pdr_fall) begin
						state_q <= ST_RST;
						low_q   <= {CW{1'b0}};
					end else if (cst_rise) begin
						state_q <= ST_CNV;
						cnt_q   <= CONV_N;
					end
				end
				ST_CNV: begin
					if (pdr_fall) begin
						state_q <= ST_RST;
						low_q   <= {CW{1'b0}};
					end else if (cnt_q <= 1 && (!last_sample || fifo_in_ready)) begin
						state_q <= ST_ACQ;
						if (last_sample) begin
							taken_q    <= 3'h0;
							acc_a_q    <= {(RES+2){1'b0}};
							acc_b_q    <= {(RES+2){1'b0}};
							result_a_q <= avg_div(sum_a, avg_cfg_q);
							result_b_q <= avg_div(sum_b, avg_cfg_q);
							push_q     <= 1'b1;
						end else begin
							taken_q <= taken_q + 3'h1;
							acc_a_q <= sum_a;
							acc_b_q <= sum_b;
						end
					end else if (cnt_q > 1) begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				ST_RST: begin
					// Abort work and restore defaults
					taken_q   <= 3'h0;
					acc_a_q   <= {(RES+2){1'b0}};
					acc_b_q   <= {(RES+2){1'b0}};
					avg_cfg_q <= `AVG_RESET_VAL;
					if (low_q != {CW{1'b1}})
						low_q <= low_q + 1'b1;
					if (low_q >= PPULSE)
						powered_down_q <= 1'b1;
					if (pdr_rise) begin
						state_q   <= ST_WAKE;
						cnt_q     <= (low_q >= PPULSE) ? PWAKE_N : RWAKE_N;
					end
				end
				ST_WAKE: begin
					if (pdr_fall) begin
						state_q <= ST_RST;
						low_q   <= {CW{1'b0}};
					end else if (cnt_q <= 1) begin
						state_q        <= ST_ACQ;
						powered_down_q <= 1'b0;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				default: state_q <= ST_ACQ;
			endcase
		end
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			acquire_state_q <= 1'b1;
			convert_state_q <= 1'b0;
		end else begin
			acquire_state_q <= (state_q == ST_ACQ);
			convert_state_q <= (state_q == ST_CNV);
		end
	end

	// ======================================================================
	// Result buffer; a full FIFO stalls the end of the conversion that completes a result
	result_fifo #(
		.WIDTH(2*RES),
		.DEPTH(8),
		.AW   (3)
	) u_fifo (
		.clock    (clock),
		.rstn     (rstn),
		.in_valid (push_q),
		.in_ready (fifo_in_ready),
		.in_data  ({result_a_q, result_b_q}),
		.out_valid(result_valid),
		.out_ready(result_ready),
		.out_data ()
	);

	// ======================================================================
	// Ready flag: rises on a new result, drops once select falls
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ready_q   <= 1'b0;
			cs_seen_q <= 1'b1;
		end else begin
			cs_seen_q <= cs_n;
			if (push_q)
				ready_q <= 1'b1;
			else if (cs_seen_q && !cs_n)
				ready_q <= 1'b0;
		end
	end
	// Zone 2 reads the held previous result; ready may be masked
	assign ready_strobe = !cs_n ? strobe_in :
		(ready_q && !(ready_mask && zone2_select));
	assign read_protocol = `DEFAULT_READ_PROTOCOL;
endmodule // conv_frame_ctrl

// File: rtl/conv_frame_regs.vh
// Constants for the conversion control and frame sequencing block
`ifndef CONV_FRAME_REGS_VH
`define CONV_FRAME_REGS_VH
// ==========================================================================
// Averaging field encodings
`define AVG_NONE_CODE     2'b00
`define AVG_TWO_CODE      2'b10
`define AVG_FOUR_CODE     2'b11
`define AVG_RESET_VAL     2'b00
// ==========================================================================
// Timing, in ns, and clock period
`define CLK_PERIOD_NS     4
`define CONV_TIME_NS      200
`define RESET_PULSE_MIN_NS 40
`define PD_PULSE_MIN_NS   4000
`define RESET_WAKE_NS     400
`define PD_WAKE_NS        20000
`define CONV_CYCLES       ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
`define RESET_PULSE_CYCLES \
	(((`RESET_PULSE_MIN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define PD_PULSE_CYCLES \
	(((`PD_PULSE_MIN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define RESET_WAKE_CYCLES \
	(((`RESET_WAKE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define PD_WAKE_CYCLES \
	(((`PD_WAKE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
// ==========================================================================
// Default read protocol code (single lane, mode 0)
`define DEFAULT_READ_PROTOCOL 3'b000
`endif

// File: sim/conv_frame_ctrl_tb.sv
// Testbench for the conversion frame control block
module conv_frame_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock, rstn, zone2_select, ready_mask, strobe_in;
	logic        result_ready, result_valid, ready_strobe;
	logic        acquire_state_q, convert_state_q, powered_down_q;
	logic        conversion_start_pin, powerdown_reset_n, cs_n;
	logic [1:0]  avg_count_select;
	logic [15:0] sample_a, sample_b, result_a_q, result_b_q;
	logic [2:0]  read_protocol;
	int          err_total, n_checks, cyc, n;
	conv_frame_ctrl #(
		.PD_PULSE_CYCLES(20),
		.PD_WAKE_CYCLES (30)
	) dut_u (
		.clock               (clock),
		.rstn                (rstn),
		.conversion_start_pin(conversion_start_pin),
		.powerdown_reset_n   (powerdown_reset_n),
		.cs_n                (cs_n),
		.avg_count_select    (avg_count_select),
		.zone2_select        (zone2_select),
		.ready_mask          (ready_mask),
		.strobe_in           (strobe_in),
		.sample_a            (sample_a),
		.sample_b            (sample_b),
		.result_a_q          (result_a_q),
		.result_b_q          (result_b_q),
		.result_valid        (result_valid),
		.result_ready        (result_ready),
		.ready_strobe        (ready_strobe),
		.acquire_state_q     (acquire_state_q),
		.convert_state_q     (convert_state_q),
		.powered_down_q      (powered_down_q),
		.read_protocol       (read_protocol)
	);
	host_model host_u (
		.clock               (clock),
		.conversion_start_pin(conversion_start_pin),
		.powerdown_reset_n   (powerdown_reset_n),
		.cs_n                (cs_n)
	);
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// ==========================================================
	// Shared tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic conv(input logic [15:0] a, b, input logic rdy);
		sample_a = a;
		sample_b = b;
		host_u.start();
		chk(ready_strobe, rdy);
	endtask
	task automatic res(input logic [15:0] a, b);
		chk(result_a_q, a);
		chk(result_b_q, b);
	endtask
	task automatic frame_read();
		strobe_in = 1'b1;
		host_u.frame();
		strobe_in = 1'b0;
		result_ready = 1'b1;
		// Let the pin settle before looking at it
		@(negedge clock) result_ready = 1'b0;
		chk(ready_strobe, 1'b0);
	endtask
	task automatic wait_acq();
		for (n = 0; n < 300 && acquire_state_q !== 1'b1; n++)
			@(negedge clock);
	endtask
	// ==========================================================
	// Scenarios
	task automatic test_reset_state();
		chk(acquire_state_q, 1'b1);
		chk({convert_state_q, powered_down_q, result_valid}, 3'h0);
		chk(read_protocol, 3'b000);
		$display("test reset_state done");
	endtask
	task automatic test_single();
		for (int c = 0; c < 2; c++) begin
			avg_count_select = c[1:0];
			conv(16'h1234 + c[15:0], 16'hfedc, 1'b1);
			res(16'h1234 + c[15:0], 16'hfedc);
			chk(result_valid, 1'b1);
			frame_read();
		end
		$display("test single done");
	endtask
	task automatic test_avg2();
		avg_count_select = 2'b10;
		conv(16'h0004, 16'hfff0, 1'b0);
		conv(16'h0008, 16'hfff4, 1'b1);
		res(16'h0006, 16'hfff2);
		frame_read();
		$display("test avg2 done");
	endtask
	task automatic test_avg4();
		avg_count_select = 2'b11;
		conv(16'h0001, 16'hffff, 1'b0);
		conv(16'h0002, 16'hfffe, 1'b0);
		conv(16'h0003, 16'hfffd, 1'b0);
		conv(16'h0006, 16'hfffc, 1'b1);
		res(16'h0003, 16'hfffd);
		frame_read();
		$display("test avg4 done");
	endtask
	// Masked ready stays low in zone 2 although a result is queued
	task automatic test_zone2();
		{zone2_select, ready_mask} = 2'b11;
		avg_count_select = 2'b00;
		conv(16'h0abc, 16'h8001, 1'b0);
		res(16'h0abc, 16'h8001);
		chk(result_valid, 1'b1);
		frame_read();
		{zone2_select, ready_mask} = 2'b00;
		$display("test zone2 done");
	endtask
	// Ninth result finds the buffer full and must wait
	task automatic test_fifo();
		avg_count_select = 2'b00;
		for (int i = 0; i < 9; i++)
			conv(i[15:0], ~i[15:0], 1'b1);
		chk(convert_state_q, 1'b1);
		result_ready = 1'b1;
		for (n = 0; n < 20 && result_valid === 1'b1; n++)
			@(negedge clock);
		result_ready = 1'b0;
		chk(n, 9);
		chk(result_a_q, 16'h0008);
		host_u.frame();
		$display("test fifo done");
	endtask
	task automatic test_pd();
		fork
			host_u.start();
		join_none
		repeat (12) @(negedge clock);
		chk(convert_state_q, 1'b1);
		host_u.pd_pulse(14);
		chk({acquire_state_q, convert_state_q}, 2'b00);
		wait_acq();
		chk(n >= 95 && n < 200, 1'b1);
		chk(result_valid, 1'b0);
		fork
			host_u.pd_pulse(40);
		join_none
		repeat (38) @(negedge clock);
		chk(powered_down_q, 1'b1);
		repeat (3) @(negedge clock);
		wait_acq();
		chk(n >= 27 && n < 60, 1'b1);
		chk(powered_down_q, 1'b0);
		$display("test pd done");
	endtask
	// ==========================================================
	// Main sequence and hang guard
	initial begin
		rstn = 1'b0;
		{zone2_select, ready_mask, strobe_in, result_ready} = 4'h0;
		avg_count_select = 2'b00;
		sample_a = 16'h0000;
		sample_b = 16'h0000;
		repeat (10) @(negedge clock);
		rstn = 1'b1;
		test_reset_state();
		test_single();
		test_avg2();
		test_avg4();
		test_zone2();
		test_fifo();
		test_pd();
		tally_and_finish();
	end
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			tally_and_finish();
		end
	end
endmodule // conv_frame_ctrl_tb

// File: sim/frame_checker.sv
// Assertion checker for the conversion frame control block
module frame_checker #(
	parameter RES = 16
) (
	input logic           clock,
	input logic           rstn,
	input logic           powerdown_reset_n,
	input logic           cs_n,
	input logic           zone2_select,
	input logic           ready_mask,
	input logic           strobe_in,
	input logic [RES-1:0] result_a_q,
	input logic           result_valid,
	input logic           ready_strobe,
	input logic           acquire_state_q,
	input logic           convert_state_q,
	input logic           powered_down_q,
	input logic [2:0]     read_protocol
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// ==========================================================
	// Assertions
	a_proto_default: assert property (
		read_protocol == 3'b000)
		else $error("read protocol not default");
	a_strobe_mux: assert property (
		!cs_n |-> ready_strobe == strobe_in)
		else $error("strobe not passed while selected");
	a_states_excl: assert property (
		!(acquire_state_q && convert_state_q))
		else $error("acquire and convert together");
	a_conv_from_acq: assert property (
		$rose(convert_state_q) |-> $past(acquire_state_q))
		else $error("convert entered outside acquire");
	// Abort by the pin is legal, so it lifts the length check
	a_conv_length: assert property (
		disable iff (!rstn || !powerdown_reset_n)
		$rose(convert_state_q) |-> convert_state_q[*8])
		else $error("conversion cut short");
	a_done_to_acq: assert property (
		$fell(convert_state_q) && powerdown_reset_n
		|-> ##[0:1] acquire_state_q)
		else $error("no acquire after conversion");
	a_pin_leaves_acq: assert property (
		$fell(powerdown_reset_n) |-> ##[1:6] !acquire_state_q)
		else $error("acquire kept after pin fall");
	a_ready_cause: assert property (
		$rose(ready_strobe) && cs_n && $past(cs_n)
		|-> $past(convert_state_q) || $past(convert_state_q, 2))
		else $error("ready without conversion end");
	a_ready_valid: assert property (
		$rose(ready_strobe) && cs_n |-> ##[0:2] result_valid)
		else $error("ready without queued result");
	a_result_cause: assert property (
		!$stable(result_a_q)
		|-> $past(convert_state_q) || $past(convert_state_q, 2))
		else $error("result moved outside conversion end");
	a_pd_no_acq: assert property (
		powered_down_q |-> !acquire_state_q && !convert_state_q)
		else $error("acquire or convert while powered down");
	a_ready_masked: assert property (
		cs_n && zone2_select && ready_mask |-> !ready_strobe)
		else $error("ready shown while masked");
	c_conv: cover property ($rose(convert_state_q));
	c_ready: cover property ($rose(ready_strobe) && cs_n);
	c_pin: cover property ($fell(powerdown_reset_n));
endmodule // frame_checker

bind conv_frame_ctrl frame_checker #(.RES(RES)) chk_u (
	.clock            (clock),
	.rstn             (rstn),
	.powerdown_reset_n(powerdown_reset_n),
	.cs_n             (cs_n),
	.zone2_select     (zone2_select),
	.ready_mask       (ready_mask),
	.strobe_in        (strobe_in),
	.result_a_q       (result_a_q),
	.result_valid     (result_valid),
	.ready_strobe     (ready_strobe),
	.acquire_state_q  (acquire_state_q),
	.convert_state_q  (convert_state_q),
	.powered_down_q   (powered_down_q),
	.read_protocol    (read_protocol)
);

// File: sim/host_model.sv
// Host controller model driving start, select and power-down pins
module host_model (
	input  logic clock,
	output logic conversion_start_pin,
	output logic powerdown_reset_n,
	output logic cs_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		conversion_start_pin = 1'b0;
		powerdown_reset_n = 1'b1;
		cs_n = 1'b1;
	end
	// ==========================================================
	// Start pulse, then idle for a full cycle time of 70 clocks
	task automatic start();
		@(negedge clock) conversion_start_pin = 1'b1;
		repeat (8) @(negedge clock);
		conversion_start_pin = 1'b0;
		repeat (62) @(negedge clock);
	endtask
	// Short read, four link periods, well under two cycle times
	task automatic frame();
		@(negedge clock) cs_n = 1'b0;
		repeat (64) @(negedge clock);
		cs_n = 1'b1;
	endtask
	task automatic pd_pulse(input int n);
		@(negedge clock) powerdown_reset_n = 1'b0;
		repeat (n) @(negedge clock);
		powerdown_reset_n = 1'b1;
	endtask
endmodule // host_model
